// >>> testbench/blr_fetch_stack_model.sv
// partner: instruction fetch unit and stack memory facing the resolver
// assumes result_r is sampled on the rising edge of the same clock
module blr_fetch_stack_model #(
    parameter logic [15:0] INSTR_LEN = 16'h0002,
    parameter logic [15:0] VEC_BASE = 16'h4000
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire blr_pkg::blr_result_t result,
    output logic [15:0] next_offset,
    output logic [15:0] stack_in,
    output logic [15:0] pop_offset
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] fetch_r;
    logic [15:0] stack_ptr_r;
    logic [15:0] mem_r [0:15];
    assign next_offset = fetch_r + INSTR_LEN;
    assign stack_in = stack_ptr_r;
    assign pop_offset = mem_r[stack_ptr_r[4:1]];
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            fetch_r <= 16'h0100;
            stack_ptr_r <= 16'h0010;
            for (int k = 0; k < 16; k++) begin
                mem_r[k] <= {12'ha5a, k[3:0]};
            end
        end else if (result.valid) begin
            // fixed service entry; real vector lookup is beyond this model
            fetch_r <= result.trap_req ? VEC_BASE : result.next_fetch_offset;
            if (result.stack_we) begin
                stack_ptr_r <= result.stack_top_reg;
            end
            if (result.trap_req) begin
                mem_r[stack_ptr_r[4:1]] <= next_offset;
            end
        end
    end
endmodule

// >>> testbench/tb_top.sv
// testbench: random instruction stream with queued expectations
// assumes the resolver answers one cycle after each request
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        blr_pkg::blr_op_t op;
        blr_pkg::blr_result_t r;
    } blr_tb_exp_t;
    logic mclk;
    logic reset_n;
    logic instr_valid;
    logic divide_error;
    blr_pkg::blr_instr_t instr;
    blr_pkg::blr_flags_t flags;
    logic [15:0] count_in;
    logic [15:0] task_selector;
    logic [15:0] next_offset;
    logic [15:0] stack_in;
    logic [15:0] pop_offset;
    blr_pkg::blr_result_t result_r;
    blr_tb_exp_t exp_q[$];
    int error_cnt = 0;
    int total_checks = 0;
    logic [15:0] rnd = 16'h0046;

    blr_resolver DUT (.mclk(mclk), .reset_n(reset_n), .instr_valid(instr_valid),
        .instr(instr), .flags(flags), .next_offset(next_offset), .count_in(count_in),
        .stack_in(stack_in), .pop_offset(pop_offset), .task_selector(task_selector),
        .divide_error(divide_error), .result_r(result_r));
    blr_fetch_stack_model u_partner (.mclk(mclk), .reset_n(reset_n), .result(result_r),
        .next_offset(next_offset), .stack_in(stack_in), .pop_offset(pop_offset));

    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic cond_of(blr_pkg::blr_cc_t cc, blr_pkg::blr_flags_t f);
        logic x;
        logic [15:0] v;
        x = f.sign_flag ^ f.overflow_flag;
        v = {~(x | f.zero_flag), x | f.zero_flag, ~x, x, ~f.parity_flag, f.parity_flag,
            ~f.sign_flag, f.sign_flag, ~(f.carry_flag | f.zero_flag),
            f.carry_flag | f.zero_flag, ~f.zero_flag, f.zero_flag, ~f.carry_flag,
            f.carry_flag, ~f.overflow_flag, f.overflow_flag};
        return v[cc];
    endfunction

    function automatic blr_pkg::blr_result_t expect_of();
        blr_pkg::blr_result_t e;
        logic [15:0] c;
        e = '0;
        e.valid = 1'b1;
        e.next_fetch_offset = next_offset;
        c = count_in - 16'h0001;
        case (instr.op)
            blr_pkg::BLR_OP_JCC: e.taken = cond_of(instr.cc, flags);
            blr_pkg::BLR_OP_LOOP, blr_pkg::BLR_OP_LOOP_EQ, blr_pkg::BLR_OP_LOOP_NE: begin
                e.count_we = 1'b1;
                e.count_register = c;
                e.taken = (c != 16'h0000) && (instr.op == blr_pkg::BLR_OP_LOOP
                    || (instr.op == blr_pkg::BLR_OP_LOOP_EQ) == flags.zero_flag);
            end
            blr_pkg::BLR_OP_JCZ: e.taken = (count_in == 16'h0000);
            blr_pkg::BLR_OP_PROC_RETURN, blr_pkg::BLR_OP_TRAP_RETURN: begin
                e.next_fetch_offset = pop_offset;
                e.task_return = (instr.op == blr_pkg::BLR_OP_TRAP_RETURN)
                    & flags.nested_task_flag;
            end
            blr_pkg::BLR_OP_PROC_RETURN_IMM: begin
                e.next_fetch_offset = pop_offset;
                e.stack_we = 1'b1;
                e.stack_top_reg = stack_in + instr.imm;
            end
            blr_pkg::BLR_OP_TRAP: begin
                e.trap_req = 1'b1;
                e.trap_type = instr.trap_type;
            end
            blr_pkg::BLR_OP_TRAP_OVF: begin
                e.trap_req = flags.overflow_flag;
                e.trap_type = flags.overflow_flag ? blr_pkg::BLR_TRAP_OVERFLOW : 8'h00;
            end
            blr_pkg::BLR_OP_TASK_CALL: begin
                e.link_we = 1'b1;
                e.link_selector = task_selector;
                e.nested_set = 1'b1;
            end
            default: ;
        endcase
        if (e.taken) begin
            e.next_fetch_offset = next_offset + {{8{instr.disp[7]}}, instr.disp};
        end
        if (divide_error) begin
            e = '0;
            e.valid = 1'b1;
            e.trap_req = 1'b1;
            e.trap_type = blr_pkg::BLR_TRAP_DIVIDE;
        end
        return e;
    endfunction

    task automatic check(string name, logic [15:0] seen, logic [15:0] want);
        total_checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, want, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    initial begin
        #2000000;
        error_cnt++;
        end_sim();
    end

    initial begin
        blr_tb_exp_t e;
        forever begin
            @(negedge mclk);
            if (result_r.valid === 1'b1) begin
                e = exp_q.pop_front();
                if (e.op != blr_pkg::BLR_OP_TRAP && e.op != blr_pkg::BLR_OP_TRAP_OVF
                    && e.op != blr_pkg::BLR_OP_TASK_CALL && e.op != blr_pkg::BLR_OP_NONE) begin
                    check("fetch", result_r.next_fetch_offset, e.r.next_fetch_offset);
                end
                if (e.op >= blr_pkg::BLR_OP_JCC && e.op <= blr_pkg::BLR_OP_JCZ) begin
                    check("taken", 16'(result_r.taken), 16'(e.r.taken));
                end
                check("count_we", 16'(result_r.count_we), 16'(e.r.count_we));
                if (e.r.count_we) begin
                    check("count", result_r.count_register, e.r.count_register);
                end
                if (e.op == blr_pkg::BLR_OP_PROC_RETURN_IMM) begin
                    check("stack_we", 16'(result_r.stack_we), 16'h0001);
                    check("stack", result_r.stack_top_reg, e.r.stack_top_reg);
                end
                check("trap_req", 16'(result_r.trap_req), 16'(e.r.trap_req));
                if (e.r.trap_req) begin
                    check("trap_type", 16'(result_r.trap_type), 16'(e.r.trap_type));
                end
                if (e.op == blr_pkg::BLR_OP_TRAP_RETURN) begin
                    check("task_sw", 16'(result_r.task_return), 16'(e.r.task_return));
                end
                check("link_we", 16'(result_r.link_we), 16'(e.r.link_we));
                check("nested", 16'(result_r.nested_set), 16'(e.r.nested_set));
                if (e.r.link_we) begin
                    check("link", result_r.link_selector, e.r.link_selector);
                end
            end
            check("pending", 16'(exp_q.size() > 1), 16'h0000);
        end
    end

    initial begin
        blr_tb_exp_t ex;
        reset_n = 1'b0;
        instr_valid = 1'b0;
        instr = '0;
        flags = '0;
        count_in = 16'h0000;
        task_selector = 16'h0000;
        divide_error = 1'b0;
        repeat (8) @(posedge mclk);
        #1 reset_n = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        for (int i = 0; i < 600; i++) begin
            rnd = lfsr(rnd);
            instr_valid = (i % 7) != 6;
            instr.op = blr_pkg::blr_op_t'(i % 12);
            instr.cc = blr_pkg::blr_cc_t'((i / 12) % 16);
            instr.disp = (i % 24 == 1) ? 8'h80 : (i % 24 == 13) ? 8'h7f : rnd[7:0];
            instr.imm = {rnd[14:0], 1'b0};
            instr.trap_type = rnd[15] ? rnd[10:3] : {6'h00, rnd[4], rnd[4]};
            flags = blr_pkg::blr_flags_t'(rnd[13:8]);
            count_in = (rnd[2:1] == 2'h0) ? {15'h0000, rnd[0]} : rnd ^ 16'h5a5a;
            task_selector = rnd ^ 16'h0f0f;
            divide_error = (i % 53) == 20;
            if (instr_valid) begin
                ex.op = divide_error ? blr_pkg::BLR_OP_TRAP : instr.op;
                ex.r = expect_of();
                exp_q.push_back(ex);
            end
            @(posedge mclk);
            #1;
        end
        instr_valid = 1'b0;
        divide_error = 1'b0;
        for (int w = 0; w < 20 && exp_q.size() != 0; w++) begin
            @(posedge mclk);
        end
        check("drain", 16'(exp_q.size()), 16'h0000);
        end_sim();
    end
endmodule

// >>> verilog/blr_cond_eval.sv
// condition evaluator for conditional jumps
// assumes flags are stable in the cycle the code is presented
module blr_cond_eval (
    input wire blr_pkg::blr_cc_t cc,
    input wire blr_pkg::blr_flags_t flags,
    output logic taken
);
    logic sxo;
    always_comb begin
        sxo = flags.sign_flag ^ flags.overflow_flag;
        unique case (cc)
            blr_pkg::BLR_CC_O: taken = flags.overflow_flag;
            blr_pkg::BLR_CC_NO: taken = !flags.overflow_flag;
            blr_pkg::BLR_CC_S: taken = flags.sign_flag;
            blr_pkg::BLR_CC_NS: taken = !flags.sign_flag;
            blr_pkg::BLR_CC_B: taken = flags.carry_flag;
            blr_pkg::BLR_CC_AE: taken = !flags.carry_flag;
            blr_pkg::BLR_CC_E: taken = flags.zero_flag;
            blr_pkg::BLR_CC_NE: taken = !flags.zero_flag;
            blr_pkg::BLR_CC_BE: taken = flags.carry_flag | flags.zero_flag;
            blr_pkg::BLR_CC_A: taken = !(flags.carry_flag | flags.zero_flag);
            blr_pkg::BLR_CC_PE: taken = flags.parity_flag;
            blr_pkg::BLR_CC_PO: taken = !flags.parity_flag;
            // less is the exact complement of ge, not a copy of it
            blr_pkg::BLR_CC_L: taken = sxo;
            blr_pkg::BLR_CC_GE: taken = !sxo;
            blr_pkg::BLR_CC_LE: taken = sxo | flags.zero_flag;
            blr_pkg::BLR_CC_G: taken = !(sxo | flags.zero_flag);
        endcase
    end
endmodule

// >>> verilog/blr_pkg.sv
// package: shared types and constants for the branch, loop and trap resolver
// assumes one clock domain; decoded instruction arrives as a one-cycle strobe
package blr_pkg;
    localparam logic [1:0] BLR_RST_SYNC = 2'h0;
    localparam logic [15:0] BLR_RST_WORD = 16'h0000;
    localparam logic [7:0] BLR_TRAP_DIVIDE = 8'h00;
    localparam logic [7:0] BLR_TRAP_BREAK = 8'h03;
    localparam logic [7:0] BLR_TRAP_OVERFLOW = 8'h04;
    localparam logic [15:0] BLR_DISP_MIN = 16'hff80;
    localparam logic [15:0] BLR_DISP_MAX = 16'h007f;

    typedef enum logic [3:0] {
        BLR_OP_NONE,
        BLR_OP_JCC,
        BLR_OP_LOOP,
        BLR_OP_LOOP_EQ,
        BLR_OP_LOOP_NE,
        BLR_OP_JCZ,
        BLR_OP_PROC_RETURN,
        BLR_OP_PROC_RETURN_IMM,
        BLR_OP_TRAP_RETURN,
        BLR_OP_TRAP,
        BLR_OP_TRAP_OVF,
        BLR_OP_TASK_CALL
    } blr_op_t;

    // condition codes; alternate spellings share one code
    typedef enum logic [3:0] {
        BLR_CC_O, BLR_CC_NO, BLR_CC_B, BLR_CC_AE,
        BLR_CC_E, BLR_CC_NE, BLR_CC_BE, BLR_CC_A,
        BLR_CC_S, BLR_CC_NS, BLR_CC_PE, BLR_CC_PO,
        BLR_CC_L, BLR_CC_GE, BLR_CC_LE, BLR_CC_G
    } blr_cc_t;

    typedef struct packed {
        logic carry_flag;
        logic zero_flag;
        logic sign_flag;
        logic overflow_flag;
        logic parity_flag;
        logic nested_task_flag;
    } blr_flags_t;

    typedef struct packed {
        blr_op_t op;
        blr_cc_t cc;
        logic [7:0] disp;
        logic [15:0] imm;
        logic [7:0] trap_type;
    } blr_instr_t;

    typedef struct packed {
        logic valid;
        logic taken;
        logic [15:0] next_fetch_offset;
        logic [15:0] count_register;
        logic count_we;
        logic [15:0] stack_top_reg;
        logic stack_we;
        logic trap_req;
        logic [7:0] trap_type;
        logic task_return;
        logic link_we;
        logic [15:0] link_selector;
        logic nested_set;
    } blr_result_t;
endpackage

// >>> verilog/blr_resolver.sv
// branch, loop and trap resolver: decides next fetch offset per instruction
// assumes decoder strobes instr_valid once per instruction, same clock;
// stack contents (return offset) are read by the caller and given as pop_offset
module blr_resolver (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic instr_valid,
    input wire blr_pkg::blr_instr_t instr,
    input wire blr_pkg::blr_flags_t flags,
    input wire logic [15:0] next_offset,
    input wire logic [15:0] count_in,
    input wire logic [15:0] stack_in,
    input wire logic [15:0] pop_offset,
    input wire logic [15:0] task_selector,
    input wire logic divide_error,
    output blr_pkg::blr_result_t result_r
);
    logic [1:0] rst_sync_r;
    logic rst_n;
    logic cc_taken;
    logic [15:0] rel_target;
    logic [15:0] count_dec;
    blr_pkg::blr_result_t result_nxt;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_r <= blr_pkg::BLR_RST_SYNC;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    blr_cond_eval u_cond (
        .cc(instr.cc),
        .flags(flags),
        .taken(cc_taken)
    );

    blr_target_add u_add (
        .next_offset(next_offset),
        .disp(instr.disp),
        .target(rel_target)
    );

    // wraps 0 -> ffff so a zero start runs 65536 passes
    assign count_dec = count_in - 16'h0001;

    always_comb begin
        result_nxt = '0;
        result_nxt.valid = instr_valid;
        result_nxt.next_fetch_offset = next_offset;
        result_nxt.count_register = count_in;
        result_nxt.stack_top_reg = stack_in;
        if (instr_valid && divide_error) begin
            // divide fault has its own fixed vector
            result_nxt.trap_req = 1'b1;
            result_nxt.trap_type = blr_pkg::BLR_TRAP_DIVIDE;
        end else if (instr_valid) begin
            unique case (instr.op)
                blr_pkg::BLR_OP_JCC: begin
                    result_nxt.taken = cc_taken;
                end
                blr_pkg::BLR_OP_LOOP: begin
                    result_nxt.count_we = 1'b1;
                    result_nxt.count_register = count_dec;
                    result_nxt.taken = count_dec != 16'h0000;
                end
                blr_pkg::BLR_OP_LOOP_EQ: begin
                    result_nxt.count_we = 1'b1;
                    result_nxt.count_register = count_dec;
                    result_nxt.taken = (count_dec != 16'h0000) && flags.zero_flag;
                end
                blr_pkg::BLR_OP_LOOP_NE: begin
                    result_nxt.count_we = 1'b1;
                    result_nxt.count_register = count_dec;
                    result_nxt.taken = (count_dec != 16'h0000) && !flags.zero_flag;
                end
                blr_pkg::BLR_OP_JCZ: begin
                    result_nxt.taken = count_in == 16'h0000;
                end
                blr_pkg::BLR_OP_PROC_RETURN: begin
                    result_nxt.next_fetch_offset = pop_offset;
                end
                blr_pkg::BLR_OP_PROC_RETURN_IMM: begin
                    // odd immediates are software's fault; added as given
                    result_nxt.next_fetch_offset = pop_offset;
                    result_nxt.stack_we = 1'b1;
                    result_nxt.stack_top_reg = stack_in + instr.imm;
                end
                blr_pkg::BLR_OP_TRAP_RETURN: begin
                    result_nxt.task_return = flags.nested_task_flag;
                    // saved offset already points past the trapping instruction
                    result_nxt.next_fetch_offset = pop_offset;
                end
                blr_pkg::BLR_OP_TRAP: begin
                    result_nxt.trap_req = 1'b1;
                    result_nxt.trap_type = instr.trap_type;
                end
                blr_pkg::BLR_OP_TRAP_OVF: begin
                    result_nxt.trap_req = flags.overflow_flag;
                    result_nxt.trap_type = flags.overflow_flag ?
                        blr_pkg::BLR_TRAP_OVERFLOW : 8'h00;
                end
                blr_pkg::BLR_OP_TASK_CALL: begin
                    result_nxt.link_we = 1'b1;
                    result_nxt.link_selector = task_selector;
                    result_nxt.nested_set = 1'b1;
                end
                default: begin
                end
            endcase
            if (result_nxt.taken) begin
                result_nxt.next_fetch_offset = rel_target;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            result_r <= '0;
        end else begin
            result_r <= result_nxt;
        end
    end

    property p_loop_dec;
        @(posedge mclk) disable iff (!rst_n)
        instr_valid && !divide_error && instr.op == blr_pkg::BLR_OP_LOOP
            |=> result_r.count_we && result_r.count_register == $past(count_in) - 16'h0001;
    endproperty
    a_loop_dec: assert property (p_loop_dec) else $error("loop count not decremented");

    property p_loop_eq;
        @(posedge mclk) disable iff (!rst_n)
        instr_valid && !divide_error && instr.op == blr_pkg::BLR_OP_LOOP_EQ && !flags.zero_flag
            |=> !result_r.taken;
    endproperty
    a_loop_eq: assert property (p_loop_eq) else $error("loop-equal taken with zero clear");

    property p_loop_ne;
        @(posedge mclk) disable iff (!rst_n)
        instr_valid && !divide_error && instr.op == blr_pkg::BLR_OP_LOOP_NE && flags.zero_flag
            |=> !result_r.taken;
    endproperty
    a_loop_ne: assert property (p_loop_ne) else $error("loop-unequal taken with zero set");

    property p_jcz;
        @(posedge mclk) disable iff (!rst_n)
        instr_valid && !divide_error && instr.op == blr_pkg::BLR_OP_JCZ
            |=> result_r.taken == ($past(count_in) == 16'h0000) && !result_r.count_we;
    endproperty
    a_jcz: assert property (p_jcz) else $error("count-zero jump wrong");

    property p_target;
        @(posedge mclk) disable iff (!rst_n)
        result_r.taken |-> result_r.next_fetch_offset - $past(next_offset) + 16'h0080 <= 16'h00ff;
    endproperty
    a_target: assert property (p_target) else $error("jump distance out of byte range");

    property p_return_imm;
        @(posedge mclk) disable iff (!rst_n)
        instr_valid && !divide_error && instr.op == blr_pkg::BLR_OP_PROC_RETURN_IMM
            |=> result_r.stack_top_reg == $past(stack_in) + $past(instr.imm);
    endproperty
    a_return_imm: assert property (p_return_imm) else $error("stack not adjusted");

    property p_trap_return;
        @(posedge mclk) disable iff (!rst_n)
        instr_valid && !divide_error && instr.op == blr_pkg::BLR_OP_TRAP_RETURN
            |=> result_r.task_return == $past(flags.nested_task_flag);
    endproperty
    a_trap_return: assert property (p_trap_return) else $error("trap return path wrong");

    property p_ovf;
        @(posedge mclk) disable iff (!rst_n)
        instr_valid && !divide_error && instr.op == blr_pkg::BLR_OP_TRAP_OVF
            |=> result_r.trap_req == $past(flags.overflow_flag)
                && (!result_r.trap_req || result_r.trap_type == blr_pkg::BLR_TRAP_OVERFLOW);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow trap wrong");

    property p_task_call;
        @(posedge mclk) disable iff (!rst_n)
        instr_valid && !divide_error && instr.op == blr_pkg::BLR_OP_TASK_CALL
            |=> result_r.nested_set && result_r.link_we
                && result_r.link_selector == $past(task_selector);
    endproperty
    a_task_call: assert property (p_task_call) else $error("task call link wrong");

    // request shapes shared by the checks below
    sequence s_jcc_req;
        instr_valid && !divide_error && instr.op == blr_pkg::BLR_OP_JCC;
    endsequence

    sequence s_loop_req;
        instr_valid && !divide_error && instr.op == blr_pkg::BLR_OP_LOOP;
    endsequence

    sequence s_trap_req;
        instr_valid && !divide_error && instr.op == blr_pkg::BLR_OP_TRAP;
    endsequence

    // the immediate and trap returns take the offset the caller already popped
    sequence s_pop_req;
        instr_valid && !divide_error && (instr.op == blr_pkg::BLR_OP_PROC_RETURN_IMM
            || instr.op == blr_pkg::BLR_OP_TRAP_RETURN);
    endsequence

    property p_divide;
        @(posedge mclk) disable iff (!rst_n)
        instr_valid && divide_error
            |=> result_r.trap_req && result_r.trap_type == blr_pkg::BLR_TRAP_DIVIDE
                && !result_r.taken && !result_r.count_we;
    endproperty
    a_divide: assert property (p_divide) else $error("divide trap wrong");

    property p_trap;
        @(posedge mclk) disable iff (!rst_n)
        s_trap_req |=> result_r.trap_req && result_r.trap_type == $past(instr.trap_type);
    endproperty
    a_trap: assert property (p_trap) else $error("software trap type wrong");

    property p_break;
        @(posedge mclk) disable iff (!rst_n)
        s_trap_req ##0 instr.trap_type == blr_pkg::BLR_TRAP_BREAK
            |=> result_r.trap_type == blr_pkg::BLR_TRAP_BREAK;
    endproperty
    a_break: assert property (p_break) else $error("breakpoint trap type wrong");

    property p_cc_above;
        @(posedge mclk) disable iff (!rst_n)
        s_jcc_req ##0 instr.cc == blr_pkg::BLR_CC_A
            |=> result_r.taken == !($past(flags.carry_flag) || $past(flags.zero_flag));
    endproperty
    a_cc_above: assert property (p_cc_above) else $error("above test wrong");

    property p_cc_odd;
        @(posedge mclk) disable iff (!rst_n)
        s_jcc_req ##0 instr.cc == blr_pkg::BLR_CC_PO
            |=> result_r.taken == !$past(flags.parity_flag);
    endproperty
    a_cc_odd: assert property (p_cc_odd) else $error("parity odd test wrong");

    property p_cc_less;
        @(posedge mclk) disable iff (!rst_n)
        s_jcc_req ##0 instr.cc == blr_pkg::BLR_CC_L
            |=> result_r.taken == ($past(flags.sign_flag) != $past(flags.overflow_flag));
    endproperty
    a_cc_less: assert property (p_cc_less) else $error("less test wrong");

    property p_cc_greater;
        @(posedge mclk) disable iff (!rst_n)
        s_jcc_req ##0 instr.cc == blr_pkg::BLR_CC_G
            |=> result_r.taken == (!$past(flags.zero_flag)
                && $past(flags.sign_flag) == $past(flags.overflow_flag));
    endproperty
    a_cc_greater: assert property (p_cc_greater) else $error("greater test wrong");

    property p_cc_sign;
        @(posedge mclk) disable iff (!rst_n)
        s_jcc_req ##0 instr.cc == blr_pkg::BLR_CC_S
            |=> result_r.taken == $past(flags.sign_flag);
    endproperty
    a_cc_sign: assert property (p_cc_sign) else $error("sign test wrong");

    // a jump not taken must leave fetch on the following instruction
    property p_jcc_fetch;
        @(posedge mclk) disable iff (!rst_n)
        s_jcc_req |=> result_r.next_fetch_offset == (result_r.taken
            ? $past(next_offset) + 16'($signed($past(instr.disp))) : $past(next_offset));
    endproperty
    a_jcc_fetch: assert property (p_jcc_fetch) else $error("jump target wrong");

    property p_loop_last;
        @(posedge mclk) disable iff (!rst_n)
        s_loop_req ##0 count_in == 16'h0001
            |=> !result_r.taken && result_r.next_fetch_offset == $past(next_offset);
    endproperty
    a_loop_last: assert property (p_loop_last) else $error("loop did not exit");

    property p_loop_wrap;
        @(posedge mclk) disable iff (!rst_n)
        s_loop_req ##0 count_in == 16'h0000
            |=> result_r.taken && result_r.count_register == 16'hffff;
    endproperty
    a_loop_wrap: assert property (p_loop_wrap) else $error("zero count did not wrap");

    property p_pop_fetch;
        @(posedge mclk) disable iff (!rst_n)
        s_pop_req |=> result_r.next_fetch_offset == $past(pop_offset) && !result_r.trap_req;
    endproperty
    a_pop_fetch: assert property (p_pop_fetch) else $error("return offset wrong");
endmodule

// >>> verilog/blr_target_add.sv
// relative target adder: sign-extended byte displacement plus offset
// assumes offset already points at the following instruction
module blr_target_add (
    input wire logic [15:0] next_offset,
    input wire logic [7:0] disp,
    output logic [15:0] target
);
    // wraps modulo 65536 within the current code segment
    always_comb begin
        target = next_offset + {{8{disp[7]}}, disp};
    end
endmodule
